// ---- sleep_mode_clock_gating.sv ----
// Sleep state control and clock gating for core, buses and the frequency locked loop.
// Assumes core strobes on mclk_i; peripheral requests, wakes and lock are asynchronous.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Idle stops the core and the level-selected clocks, ignoring bus clock masks.
// - Instruction wait with deep select zero enters idle; software sets level first.
// - Sleep-after-handler also enters the chosen sleep on lowest handler return.
// - Unmasked, high-enough interrupt ends idle and restarts core and modules.
// - Instruction wait with deep select one enters standby; regulator and RAM low power.
// - Standby stops all clocks except a keep-in-standby oscillator, when requested or always-on.
// - Only an enabled asynchronous peripheral interrupt ends standby.
// - After standby wake, core takes handler or resumes per global mask.
// - Peripheral may wake its clock in standby without waking the core.
// - With request-driven run set, oscillator runs only while requested.
// - With request-driven run clear, enabled oscillator runs always outside standby.
// - In standby oscillator is off unless keep-in-standby; then on-demand still applies.
// - Keep-in-standby plus on-demand runs on request; without on-demand runs always.
// - Lock-wait chooses output before lock or only after lock.
// - Skip-coarse-lock set bypasses coarse lock; clear performs it.
// - Fast-lock-off set disables quick lock; clear uses it.
// - Cool-cycle-off set omits chill cycles; clear keeps them.
// - Idle level 0 stops core, 1 adds AHB, 2 adds APB; always-on oscillators run.
module sleep_mode_clock_gating
	import sleep_pkg::*;
#(
	parameter int NREQ = 4
) (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Register port
	input wire logic [sleep_pkg::ADDR_W-1:0] addr_i,
	input wire logic [sleep_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [sleep_pkg::DATA_W-1:0] rdata_o,
	// Core side
	input wire logic wait_for_interrupt_instr_i,
	input wire logic handler_return_i,
	input wire logic irq_pending_i,
	input wire logic global_interrupt_mask_i,
	output logic take_irq_o,
	output logic resume_o,
	// Peripheral side, asynchronous
	input wire logic [NREQ-1:0] clk_req_i,
	input wire logic [NREQ-1:0] async_wake_i,
	input wire logic loop_locked_i,
	// Clock gates and power modes
	output logic core_clk_en_o,
	output logic ahb_clk_en_o,
	output logic apb_clk_en_o,
	output logic regulator_lp_o,
	output logic ram_lp_o,
	// Frequency locked loop controls
	output logic osc_en_o,
	output logic loop_clk_out_o,
	output logic coarse_lock_en_o,
	output logic quick_lock_en_o,
	output logic chill_en_o
);
	import sleep_pkg::*;

	// Status word carries at most 16 request bits
	if (NREQ < 1 || NREQ > 16) begin : g_nreq_bad
		$error("NREQ must be 1 to 16");
	end

	power_state_e state;
	power_state_e next_state;
	logic [15:0] freq_loop_control;
	logic [3:0] sleep_config;
	logic [NREQ-1:0] wake_enable;
	logic [NREQ-1:0] req_sync;
	logic [NREQ-1:0] wake_sync;
	logic locked;
	logic req_any;
	logic sleep_go;
	logic stby_wake;
	logic [1:0] idle_level;
	logic deep_sel;
	logic after_handler;
	logic loop_en;
	logic on_demand;
	logic keep_stby;
	logic lock_wait;

	// Asynchronous inputs share one synchroniser
	sync_if #(.W(2 * NREQ + 1)) sync_bus ();
	assign sync_bus.raw = {loop_locked_i, async_wake_i, clk_req_i};
	assign {locked, wake_sync, req_sync} = sync_bus.clean;

	in_sync #(.W(2 * NREQ + 1)) u_sync (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.port(sync_bus)
	);

	// Field views
	assign idle_level = sleep_config[IDLE_LEVEL_LSB +: 2];
	assign deep_sel = sleep_config[DEEP_SLEEP_SELECT_BIT];
	assign after_handler = sleep_config[SLEEP_AFTER_HANDLER_BIT];
	assign loop_en = freq_loop_control[LOOP_ENABLE_BIT];
	assign on_demand = freq_loop_control[REQUEST_DRIVEN_RUN_BIT];
	assign keep_stby = freq_loop_control[KEEP_IN_STANDBY_BIT];
	assign lock_wait = freq_loop_control[LOCK_WAIT_BIT];

	assign req_any = |req_sync;
	// or on return from last handler
	assign sleep_go = wait_for_interrupt_instr_i || (handler_return_i && after_handler);
	assign stby_wake = |(wake_sync & wake_enable);

	// Power state sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			ACTIVE_S: begin
				if (sleep_go) begin
					next_state = deep_sel ? STANDBY_S : IDLE_S;
				end
			end
			IDLE_S: begin
				if (irq_pending_i) begin
					next_state = WAKE_S;
				end
			end
			STANDBY_S: begin
				if (stby_wake) begin
					next_state = WAKE_S;
				end
			end
			WAKE_S: begin
				next_state = ACTIVE_S;
			end
			default: begin
				next_state = ACTIVE_S;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			state <= ACTIVE_S;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	// handler or resume chosen on leaving wake
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			take_irq_o <= 1'b0;
			resume_o <= 1'b0;
		end else if (ce_i) begin
			take_irq_o <= (state == WAKE_S) && !global_interrupt_mask_i;
			resume_o <= (state == WAKE_S) && global_interrupt_mask_i;
		end
	end

	// core only after bus clocks are back
	assign core_clk_en_o = (state == ACTIVE_S);
	assign ahb_clk_en_o = (state == ACTIVE_S) || (state == WAKE_S) ||
		((state == IDLE_S) && (idle_level == IDLE_CPU));
	assign apb_clk_en_o = (state == ACTIVE_S) || (state == WAKE_S) ||
		((state == IDLE_S) && (idle_level <= IDLE_AHB));
	// low power supply and RAM in standby
	assign regulator_lp_o = (state == STANDBY_S);
	assign ram_lp_o = (state == STANDBY_S);

	// Oscillator gating; with keep-in-standby set, requests also wake it in standby for sleepwalking
	always_comb begin
		if (!loop_en) begin
			osc_en_o = 1'b0;
		end else if (state == STANDBY_S) begin
			// standby keeps only requested or always-on
			// request runs clock with core asleep
			osc_en_o = keep_stby && (!on_demand || req_any);
		end else begin
			osc_en_o = !on_demand || req_any;
		end
	end

	// hold output until lock when asked
	assign loop_clk_out_o = osc_en_o && (!lock_wait || locked);
	assign coarse_lock_en_o = !freq_loop_control[SKIP_COARSE_LOCK_BIT];
	assign quick_lock_en_o = !freq_loop_control[FAST_LOCK_OFF_BIT];
	assign chill_en_o = !freq_loop_control[COOL_CYCLE_OFF_BIT];

	// Register writes; unimplemented bits never stored
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			freq_loop_control <= FREQ_LOOP_CONTROL_RST;
			sleep_config <= SLEEP_CONFIG_RST;
			wake_enable <= WAKE_ENABLE_RST[NREQ-1:0];
		end else if (ce_i && wr_i) begin
			if (addr_i == FREQ_LOOP_CONTROL_OFS) begin
				freq_loop_control <= wdata_i[15:0] & FREQ_LOOP_CONTROL_MASK;
			end
			if (addr_i == SLEEP_CONFIG_OFS) begin
				sleep_config <= wdata_i[3:0];
			end
			if (addr_i == WAKE_ENABLE_OFS) begin
				wake_enable <= wdata_i[NREQ-1:0];
			end
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			rdata_o <= '0;
			if (rd_i) begin
				unique case (addr_i)
					FREQ_LOOP_CONTROL_OFS: rdata_o[15:0] <= freq_loop_control;
					SLEEP_CONFIG_OFS: rdata_o[3:0] <= sleep_config;
					WAKE_ENABLE_OFS: rdata_o[NREQ-1:0] <= wake_enable;
					SLEEP_STATUS_OFS: begin
						rdata_o[STATUS_STATE_LSB +: 3] <= state;
						rdata_o[STATUS_OSC_ON_BIT] <= osc_en_o;
						rdata_o[STATUS_LOCKED_BIT] <= locked;
						rdata_o[STATUS_SLEEPWALK_BIT] <= (state == STANDBY_S) && req_any;
						rdata_o[STATUS_REQ_LSB +: NREQ] <= req_sync;
					end
					default: rdata_o <= '0;
				endcase
			end
		end
	end

	// Checks on sequencing and gating
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_idle_irq;
		ce_i && state == IDLE_S && irq_pending_i;
	endsequence
	sequence s_bus_first;
		state == WAKE_S && ahb_clk_en_o && apb_clk_en_o && !core_clk_en_o;
	endsequence
	sequence s_stby_irq;
		ce_i && state == STANDBY_S && stby_wake;
	endsequence

	a_idle_core_stop: assert property (state == IDLE_S |-> !core_clk_en_o)
		else $error("core clock runs in idle");
	a_idle_entry_wait: assert property (ce_i && state == ACTIVE_S && wait_for_interrupt_instr_i && !deep_sel
		|=> state == IDLE_S)
		else $error("no idle after wait instruction");
	a_after_handler_sleep: assert property (ce_i && state == ACTIVE_S && handler_return_i && after_handler
		&& deep_sel |=> state == STANDBY_S)
		else $error("no sleep after handler return");
	a_idle_wake_seq: assert property (s_idle_irq |=> s_bus_first)
		else $error("idle wake did not restore buses first");
	a_stby_wake_seq: assert property (s_stby_irq |=> s_bus_first)
		else $error("standby wake did not restore buses first");
	a_standby_low_power: assert property (state == STANDBY_S |-> regulator_lp_o && ram_lp_o
		&& !ahb_clk_en_o && !apb_clk_en_o)
		else $error("standby power modes wrong");
	a_stby_hold: assert property (ce_i && state == STANDBY_S && !stby_wake |=> state == STANDBY_S)
		else $error("standby left without enabled wake");
	a_wake_handler: assert property (ce_i && state == WAKE_S && !global_interrupt_mask_i
		|=> take_irq_o && !resume_o)
		else $error("handler not taken after wake");
	a_demand_off: assert property (state != STANDBY_S && on_demand && !req_any |-> !osc_en_o)
		else $error("on-demand oscillator runs without request");
	a_always_on: assert property (state != STANDBY_S && loop_en && !on_demand |-> osc_en_o)
		else $error("always-on oscillator stopped");
	a_stby_osc_off: assert property (state == STANDBY_S && !keep_stby |-> !osc_en_o)
		else $error("oscillator runs in standby");
	a_stby_keep_run: assert property (state == STANDBY_S && loop_en && keep_stby && !on_demand |-> osc_en_o)
		else $error("kept oscillator stopped in standby");
	a_sleepwalk_clock: assert property (state == STANDBY_S && loop_en && keep_stby && req_any
		|-> osc_en_o && !core_clk_en_o)
		else $error("sleepwalking clock not granted");
	a_lock_hold: assert property (lock_wait && !locked |-> !loop_clk_out_o)
		else $error("clock forwarded before lock");
	a_idle_apb_stop: assert property (state == IDLE_S && idle_level > IDLE_AHB |-> !apb_clk_en_o && !ahb_clk_en_o)
		else $error("bus clocks run in deepest idle");
	a_wake_resume: assert property (ce_i && state == WAKE_S && global_interrupt_mask_i
		|=> resume_o && !take_irq_o)
		else $error("program not resumed after wake");
	a_idle_hold: assert property (ce_i && state == IDLE_S && !irq_pending_i |=> state == IDLE_S)
		else $error("idle left without interrupt");
	a_handler_stays: assert property (ce_i && state == ACTIVE_S && handler_return_i && !after_handler
		&& !wait_for_interrupt_instr_i |=> state == ACTIVE_S)
		else $error("sleep entered without sleep-after-handler");
endmodule
`default_nettype wire

// ---- sleep_pkg.sv ----
// Constants, register map and state codes of the sleep and clock gating block.
// Assumes a 32-bit register port with byte addresses and one main clock.
package sleep_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] FREQ_LOOP_CONTROL_OFS = 8'h00;
	localparam logic [7:0] SLEEP_CONFIG_OFS = 8'h04;
	localparam logic [7:0] WAKE_ENABLE_OFS = 8'h08;
	localparam logic [7:0] SLEEP_STATUS_OFS = 8'h0C;

	// freq_loop_control fields
	localparam int LOOP_ENABLE_BIT = 1;
	localparam int KEEP_IN_STANDBY_BIT = 6;
	localparam int REQUEST_DRIVEN_RUN_BIT = 7;
	localparam int COOL_CYCLE_OFF_BIT = 8;
	localparam int FAST_LOCK_OFF_BIT = 9;
	localparam int SKIP_COARSE_LOCK_BIT = 10;
	localparam int LOCK_WAIT_BIT = 11;
	localparam logic [15:0] FREQ_LOOP_CONTROL_RST = 16'h0000;
	localparam logic [15:0] FREQ_LOOP_CONTROL_MASK = 16'h0FC2;

	// sleep_config fields
	localparam int IDLE_LEVEL_LSB = 0;
	localparam int DEEP_SLEEP_SELECT_BIT = 2;
	localparam int SLEEP_AFTER_HANDLER_BIT = 3;
	localparam logic [3:0] SLEEP_CONFIG_RST = 4'h0;
	localparam logic [15:0] WAKE_ENABLE_RST = 16'h0000;

	// sleep_status fields
	localparam int STATUS_STATE_LSB = 0;
	localparam int STATUS_OSC_ON_BIT = 3;
	localparam int STATUS_LOCKED_BIT = 4;
	localparam int STATUS_SLEEPWALK_BIT = 5;
	localparam int STATUS_REQ_LSB = 16;

	// Idle depth codes
	localparam logic [1:0] IDLE_CPU = 2'h0;
	localparam logic [1:0] IDLE_AHB = 2'h1;

	typedef enum logic [2:0] {
		ACTIVE_S = 3'b000,
		IDLE_S = 3'b001,
		STANDBY_S = 3'b010,
		WAKE_S = 3'b011
	} power_state_e;

endpackage

// ---- sync_if.sv ----
// Carrier between the main block and its input synchroniser.
// Assumes both ends sit on the main clock.
`timescale 1ns/1ps
`default_nettype none
interface sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport user (output raw, input clean);
	modport sync (input raw, output clean);
endinterface
`default_nettype wire

// ---- in_sync.sv ----
// Three-stage synchroniser for inputs arriving from outside the main clock.
// Assumes the raw side may change at any time; the clean side is mclk_i.
`timescale 1ns/1ps
`default_nettype none
module in_sync #(
	parameter int W = 1
) (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Carrier
	sync_if.sync port
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] clean;

	// A carrier without bits cannot be served
	if (W < 1) begin : g_w_bad
		$error("W must be at least 1");
	end

	// Shift chain; stage1 only feeds stage2 to contain metastability
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else if (ce_i) begin
			stage1 <= port.raw;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Accept a bit only once two late stages agree
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			clean <= '0;
		end else if (ce_i) begin
			for (int i = 0; i < W; i++) begin
				if (stage2[i] == stage3[i]) begin
					clean[i] <= stage3[i];
				end
			end
		end
	end

	assign port.clean = clean;
endmodule
`default_nettype wire

// ---- periph_model.sv ----
// Peripheral side of the sleep block: clock requests, wake interrupts, loop lock flag.
// Assumes the bench commands each level; outputs follow a few ns later, off the main clock.
`timescale 1ns/1ps
`default_nettype none
module periph_model #(
	parameter int NREQ = 4,
	parameter int DLY = 3
) (
	// Commands from the bench
	input wire logic [NREQ-1:0] req_cmd_i,
	input wire logic [NREQ-1:0] wake_cmd_i,
	input wire logic lock_cmd_i,
	// Asynchronous levels toward the block
	output logic [NREQ-1:0] clk_req_o,
	output logic [NREQ-1:0] async_wake_o,
	output logic lock_o
);
	// Quiet levels from time zero, so no unknown enters the synchroniser
	initial begin
		clk_req_o = '0;
		async_wake_o = '0;
		lock_o = 1'b0;
	end
	// sleepwalk requests
	// Requests may rise in standby with the core left asleep
	always @(req_cmd_i) clk_req_o <= #(DLY) req_cmd_i;
	// asynchronous wake source
	// Off-grid timing forces the block to synchronise the level
	always @(wake_cmd_i) async_wake_o <= #(DLY) wake_cmd_i;
	// Lock reported later than requests, as a slow loop would
	always @(lock_cmd_i) lock_o <= #(DLY + 2) lock_cmd_i;
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the sleep and clock gating block.
// Assumes the peripheral model drives the asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sleep_pkg::*;
	localparam int NREQ = 4;
	// Stimulus and observed signals
	logic mclk_i, rstn_i, ce_i, wr_i, rd_i, wait_for_interrupt_instr_i;
	logic handler_return_i, irq_pending_i, global_interrupt_mask_i;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o, d, q;
	logic take_irq_o, resume_o, loop_locked_i, lock_cmd;
	logic [NREQ-1:0] clk_req_i, async_wake_i, req_cmd, wake_cmd;
	logic core_clk_en_o, ahb_clk_en_o, apb_clk_en_o, regulator_lp_o, ram_lp_o;
	logic osc_en_o, loop_clk_out_o, coarse_lock_en_o, quick_lock_en_o, chill_en_o;
	logic [15:0] ctl;
	int error_cnt, n_checks, seed, i, n;

	sleep_mode_clock_gating #(.NREQ(NREQ)) i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.wait_for_interrupt_instr_i(wait_for_interrupt_instr_i),
		.handler_return_i(handler_return_i), .irq_pending_i(irq_pending_i),
		.global_interrupt_mask_i(global_interrupt_mask_i), .take_irq_o(take_irq_o), .resume_o(resume_o),
		.clk_req_i(clk_req_i), .async_wake_i(async_wake_i), .loop_locked_i(loop_locked_i),
		.core_clk_en_o(core_clk_en_o), .ahb_clk_en_o(ahb_clk_en_o), .apb_clk_en_o(apb_clk_en_o),
		.regulator_lp_o(regulator_lp_o), .ram_lp_o(ram_lp_o), .osc_en_o(osc_en_o),
		.loop_clk_out_o(loop_clk_out_o), .coarse_lock_en_o(coarse_lock_en_o),
		.quick_lock_en_o(quick_lock_en_o), .chill_en_o(chill_en_o));

	periph_model #(.NREQ(NREQ), .DLY(3)) i_periph (.req_cmd_i(req_cmd), .wake_cmd_i(wake_cmd),
		.lock_cmd_i(lock_cmd), .clk_req_o(clk_req_i), .async_wake_o(async_wake_i), .lock_o(loop_locked_i));

	// 250 MHz main clock
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	// Case equality, so an unknown never matches
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask

	// Sleep strobe from the core, then settle past the edge
	task automatic sleep_pulse(input logic hret);
		@(posedge mclk_i);
		wait_for_interrupt_instr_i <= !hret;
		handler_return_i <= hret;
		@(posedge mclk_i);
		wait_for_interrupt_instr_i <= 1'b0;
		handler_return_i <= 1'b0;
		#1;
	endtask

	// Expected oscillator enable from the control word
	function automatic logic exp_osc(input logic [15:0] c, input logic stby, input logic r);
		logic run;
		run = !c[REQUEST_DRIVEN_RUN_BIT] | r;
		return c[LOOP_ENABLE_BIT] & (stby ? c[KEEP_IN_STANDBY_BIT] & run : run);
	endfunction

	initial begin
		seed = 31307;
		error_cnt = 0;
		n_checks = 0;
		{rstn_i, wr_i, rd_i, handler_return_i, irq_pending_i, global_interrupt_mask_i} = '0;
		wait_for_interrupt_instr_i = 1'b0;
		ce_i = 1'b1;
		addr_i = '0;
		wdata_i = '0;
		req_cmd = '0;
		wake_cmd = '0;
		lock_cmd = 1'b0;
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
		// Reset contents, then the unmapped place at 0x10
		for (i = 0; i < 5; i++) begin
			rd(8'(i * 4), d);
			chk(d, 32'h0);
		end
		// Clock enable low: write and sleep strobe must both be ignored
		@(posedge mclk_i);
		ce_i <= 1'b0;
		wr(SLEEP_CONFIG_OFS, 32'hF);
		sleep_pulse(1'b0);
		chk(core_clk_en_o, 1'b1);
		@(posedge mclk_i);
		ce_i <= 1'b1;
		rd(SLEEP_CONFIG_OFS, d);
		chk(d, 32'h0);
		// Handler return without sleep-after-handler keeps the core running
		sleep_pulse(1'b1);
		chk(core_clk_en_o, 1'b1);
		// Random control words: writable mask and the three lock options
		repeat (8) begin
			d = $random(seed);
			wr(FREQ_LOOP_CONTROL_OFS, d);
			rd(FREQ_LOOP_CONTROL_OFS, q);
			chk(q, d & {16'h0, FREQ_LOOP_CONTROL_MASK});
			chk({coarse_lock_en_o, quick_lock_en_o, chill_en_o}, 3'(~{d[10], d[9], d[8]}));
		end
		// Active mode oscillator table, lock wait and lock combinations
		for (i = 0; i < 16; i++) begin
			ctl = 16'h0002 | (16'(i[0]) << KEEP_IN_STANDBY_BIT) | (16'(i[1]) << REQUEST_DRIVEN_RUN_BIT);
			ctl = ctl | (16'(i[2]) << LOCK_WAIT_BIT);
			wr(FREQ_LOOP_CONTROL_OFS, 32'(ctl));
			req_cmd <= i[3] ? (NREQ'($random(seed)) | NREQ'(1)) : '0;
			lock_cmd <= i[0];
			repeat (6) @(posedge mclk_i);
			#1;
			chk(osc_en_o, exp_osc(ctl, 1'b0, i[3]));
			chk(loop_clk_out_o, exp_osc(ctl, 1'b0, i[3]) & (!i[2] | i[0]));
		end
		// Idle levels; level 3 reached by handler return
		wr(FREQ_LOOP_CONTROL_OFS, 32'h0002);
		req_cmd <= '0;
		lock_cmd <= 1'b0;
		for (i = 0; i < 4; i++) begin
			wr(SLEEP_CONFIG_OFS, 32'(i) | (i == 3 ? 32'h8 : 32'h0));
			sleep_pulse(i == 3);
			chk({core_clk_en_o, ahb_clk_en_o, apb_clk_en_o, osc_en_o}, {1'b0, i == 0, i < 2, 1'b1});
			chk({regulator_lp_o, ram_lp_o}, 2'b00);
			@(posedge mclk_i);
			irq_pending_i <= 1'b1;
			@(posedge mclk_i);
			irq_pending_i <= 1'b0;
			#1;
			chk({core_clk_en_o, ahb_clk_en_o, apb_clk_en_o}, 3'b011);
			@(posedge mclk_i);
			#1;
			chk({core_clk_en_o, take_irq_o, resume_o}, 3'b110);
		end
		// Standby: each keep and on-demand pair, sleepwalk, refused and real wakes
		wr(WAKE_ENABLE_OFS, 32'h2);
		for (i = 0; i < 4; i++) begin
			ctl = 16'h0002 | (16'(i[0]) << KEEP_IN_STANDBY_BIT) | (16'(i[1]) << REQUEST_DRIVEN_RUN_BIT);
			wr(FREQ_LOOP_CONTROL_OFS, 32'(ctl));
			wr(SLEEP_CONFIG_OFS, i == 3 ? 32'hC : 32'h4);
			global_interrupt_mask_i <= i[0];
			sleep_pulse(i == 3);
			chk({core_clk_en_o, ahb_clk_en_o, apb_clk_en_o, regulator_lp_o, ram_lp_o}, 5'b00011);
			chk(osc_en_o, exp_osc(ctl, 1'b1, 1'b0));
			@(posedge mclk_i);
			req_cmd <= 4'h4;
			wake_cmd <= 4'h1;
			irq_pending_i <= 1'b1;
			repeat (6) @(posedge mclk_i);
			#1;
			chk({core_clk_en_o, osc_en_o}, {1'b0, exp_osc(ctl, 1'b1, 1'b1)});
			rd(SLEEP_STATUS_OFS, d);
			chk(d[5:0], {2'b10, exp_osc(ctl, 1'b1, 1'b1), 3'h2});
			chk(d[19:16], 4'h4);
			@(posedge mclk_i);
			req_cmd <= '0;
			irq_pending_i <= 1'b0;
			wake_cmd <= 4'h3;
			for (n = 0; n < 12 && ahb_clk_en_o !== 1'b1; n++) begin
				@(posedge mclk_i);
				#1;
			end
			if (n == 12) begin
				error_cnt++;
				report_and_stop();
			end
			chk(core_clk_en_o, 1'b0);
			@(posedge mclk_i);
			#1;
			chk({core_clk_en_o, take_irq_o, resume_o}, {1'b1, !i[0], i[0]});
			@(posedge mclk_i);
			wake_cmd <= '0;
			repeat (6) @(posedge mclk_i);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
